// ### hdl/qcmc_regs.vh
// register offsets, field positions and constants of the quadrature counter mode control block
// Summary of operation
// - swap bit exchanges phase a and b pins
// - compare source selects position or revolution count
// - position match with revolution count equal to shared compare sets combined flag
// - index clears position unless revolution mode 10
// - gate function counts only at chosen level
// - position stop bit halts position counting
// - revolution mode 00 off, 01 index steps
// - mode 10 wraps step, 11 wraps and index
// - position mode 00 off, 01 up/down edges
// - mode 10 counts by phase lead
// - mode 11 steps on b, a sets direction
// - index before phase edge: clear, no rev step
// - clear function index edge selection encoding
// - gate function index level selection encoding
// - phase b edge select encoding
// - phase a edge select encoding
// - mask window of two, four, eight changes
// - direction reversal ends window, events restart it
// - mask works only in revolution modes 00, 11
// - mode field change cancels mask window
// - position writes accepted only while stopped
// - underflow loads maximum position value
// - index clear of position sets zero index flag
`ifndef QCMC_REGS_VH
`define QCMC_REGS_VH
`define QCMC_ADDR_W        4
`define QCMC_ADR_CTRL_LOW  4'h0
`define QCMC_ADR_CTRL_HIGH 4'h1
`define QCMC_ADR_POS       4'h2
`define QCMC_ADR_REV       4'h3
`define QCMC_ADR_POS_CMP   4'h4
`define QCMC_ADR_SHR_CMP   4'h5
`define QCMC_ADR_MAX_POS   4'h6
`define QCMC_ADR_STATUS    4'h7
`define QCMC_CTRL_RESET    8'h00
`define QCMC_CNT_RESET     16'h0000
`define QCMC_MAX_RESET     16'hFFFF
`define QCMC_B_SWAP        7
`define QCMC_B_COMPARE_SOURCE_SELECT        6
`define QCMC_B_IFS         5
`define QCMC_B_PSTOP       4
`define QCMC_F_REVMODE     3:2
`define QCMC_F_POSMODE     1:0
`define QCMC_F_IDXEDGE     7:6
`define QCMC_F_BEDGE       5:4
`define QCMC_F_AEDGE       3:2
`define QCMC_F_MASK        1:0
`define QCMC_M_OFF         2'h0
`define QCMC_M_ONE         2'h1
`define QCMC_M_TWO         2'h2
`define QCMC_M_THREE       2'h3
`define QCMC_ST_POS_MATCH  0
`define QCMC_ST_SHR_MATCH  1
`define QCMC_ST_BOTH_MATCH 2
`define QCMC_ST_ZERO_IDX   3
`define QCMC_ST_OVF        4
`define QCMC_ST_UNF        5
`define QCMC_ST_DIR        6
`define QCMC_ST_DIR_VALID  7
`define QCMC_MASK_CNT2     4'h2
`define QCMC_MASK_CNT4     4'h4
`define QCMC_MASK_CNT8     4'h8
`endif

// ### hdl/qcmc_counter.v
// quadrature position and revolution counter with mode control and register port
`timescale 1ns/1ps
`default_nettype none
`include "qcmc_regs.vh"
module qcmc_counter #(
   parameter CW = 16
) (
   // clock and reset
   input  wire                    clock,
   input  wire                    sys_rst,
   // encoder pins
   input  wire                    phase_a_input,
   input  wire                    phase_b_input,
   input  wire                    index_input,
   // register port
   input  wire [`QCMC_ADDR_W-1:0] reg_addr,
   input  wire [CW-1:0]           reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [CW-1:0]           reg_rdata,
   // status
   output reg                     combined_match_flag,
   output reg                     zero_index_flag,
   output reg  [CW-1:0]           position_count_reg,
   output reg  [CW-1:0]           revolution_count_reg
);
   reg  [7:0]    quad_control_low;
   reg  [7:0]    quad_control_high;
   reg  [CW-1:0] position_compare_reg;
   reg  [CW-1:0] shared_compare_reg;
   reg  [CW-1:0] max_position_reg;

   reg           pos_match_reg;
   reg           shr_match_reg;
   reg           ovf_reg;
   reg           unf_reg;
   reg           last_direction_flag;
   reg           dir_valid_reg;
   reg  [3:0]    mask_cnt_reg;
   reg  [3:0]    mask_cnt_next;

   reg  [2:0]    a_sync_reg;
   reg  [2:0]    b_sync_reg;
   reg  [2:0]    z_sync_reg;

   reg  [CW-1:0] pos_next;
   reg  [CW-1:0] rev_next;
   reg           dir_next;
   reg           dir_valid_next;
   reg           step_up;
   reg           step_dn;
   reg           rev_up;
   reg           rev_dn;
   reg           do_clear;
   reg           zero_idx_set;
   reg           wrap_evt;
   reg           masked;
   reg  [CW-1:0] rdata_next;
   reg           a_act;
   reg           b_act;
   reg           z_act;
   reg           gate_ok;
   reg  [3:0]    mask_len;

   // third stage only holds the previous synced level for edge detection
   wire a_pin   = a_sync_reg[1];
   wire b_pin   = b_sync_reg[1];
   wire a_old   = a_sync_reg[2];
   wire b_old   = b_sync_reg[2];
   wire z_lvl   = z_sync_reg[1];
   wire z_old   = z_sync_reg[2];

   wire swap    = quad_control_low[`QCMC_B_SWAP];
   wire a_in    = swap ? b_pin : a_pin;
   wire b_in    = swap ? a_pin : b_pin;
   wire a_prev  = swap ? b_old : a_old;
   wire b_prev  = swap ? a_old : b_old;

   wire a_rise  = a_in & ~a_prev;
   wire a_fall  = ~a_in & a_prev;
   wire b_rise  = b_in & ~b_prev;
   wire b_fall  = ~b_in & b_prev;
   wire z_rise  = z_lvl & ~z_old;
   wire z_fall  = ~z_lvl & z_old;

   wire [1:0] pos_mode = quad_control_low[`QCMC_F_POSMODE];
   wire [1:0] rev_mode = quad_control_low[`QCMC_F_REVMODE];
   wire [1:0] a_sel    = quad_control_high[`QCMC_F_AEDGE];
   wire [1:0] b_sel    = quad_control_high[`QCMC_F_BEDGE];
   wire [1:0] z_sel    = quad_control_high[`QCMC_F_IDXEDGE];
   wire [1:0] msk_sel  = quad_control_high[`QCMC_F_MASK];
   wire gate_fn  = quad_control_low[`QCMC_B_IFS];
   wire pstop    = quad_control_low[`QCMC_B_PSTOP];

   wire run = (pos_mode != `QCMC_M_OFF) & ~pstop & gate_ok;
   wire ctrl_wr_low = reg_wr & (reg_addr == `QCMC_ADR_CTRL_LOW);
   wire pos_wr      = reg_wr & (reg_addr == `QCMC_ADR_POS);
   wire rev_wr      = reg_wr & (reg_addr == `QCMC_ADR_REV);
   wire pos_mode_chg = ctrl_wr_low & (reg_wdata[`QCMC_F_POSMODE] != pos_mode);
   wire rev_mode_chg = ctrl_wr_low & (reg_wdata[`QCMC_F_REVMODE] != rev_mode);
   wire mode_change  = pos_mode_chg | rev_mode_chg;
   wire mask_mode = (rev_mode == `QCMC_M_OFF) | (rev_mode == `QCMC_M_THREE);

   always @* begin
      case (a_sel)
         `QCMC_M_ONE:   a_act = a_fall;
         `QCMC_M_TWO:   a_act = a_rise;
         `QCMC_M_THREE: a_act = a_rise | a_fall;
         default:       a_act = 1'b0;
      endcase
   end

   always @* begin
      case (b_sel)
         `QCMC_M_ONE:   b_act = b_fall;
         `QCMC_M_TWO:   b_act = b_rise;
         `QCMC_M_THREE: b_act = b_rise | b_fall;
         default:       b_act = 1'b0;
      endcase
   end

   // index edges only clear in the clear function
   always @* begin
      z_act = 1'b0;
      if (!gate_fn) begin
         case (z_sel)
            `QCMC_M_ONE:   z_act = z_fall;
            `QCMC_M_TWO:   z_act = z_rise;
            `QCMC_M_THREE: z_act = z_rise | z_fall;
            default:       z_act = 1'b0;
         endcase
      end
   end

   // levels 00 and 11 give no gating, so the counter runs freely
   always @* begin
      gate_ok = 1'b1;
      if (gate_fn) begin
         case (z_sel)
            `QCMC_M_ONE: gate_ok = ~z_lvl;
            `QCMC_M_TWO: gate_ok = z_lvl;
            default:     gate_ok = 1'b1;
         endcase
      end
   end

   // no mask opens no window, so no stale count waits for a later enable
   always @* begin
      case (msk_sel)
         `QCMC_M_ONE:   mask_len = `QCMC_MASK_CNT2;
         `QCMC_M_TWO:   mask_len = `QCMC_MASK_CNT4;
         `QCMC_M_THREE: mask_len = `QCMC_MASK_CNT8;
         default:       mask_len = 4'h0;
      endcase
   end

   always @* begin
      step_up = 1'b0;
      step_dn = 1'b0;
      case (pos_mode)
         `QCMC_M_ONE: begin
            step_up = a_act & ~b_act;
            step_dn = b_act & ~a_act;
         end
         `QCMC_M_TWO: begin
            // a edge with b opposite level means a leads
            step_up = (a_act & (a_in ^ b_in)) | (b_act & ~(a_in ^ b_in));
            step_dn = (a_act & ~(a_in ^ b_in)) | (b_act & (a_in ^ b_in));
         end
         `QCMC_M_THREE: begin
            step_up = b_act & a_in;
            step_dn = b_act & ~a_in;
         end
         default: begin
            step_up = 1'b0;
            step_dn = 1'b0;
         end
      endcase
      step_up = step_up & run;
      step_dn = step_dn & run;
   end

   always @* begin
      pos_next       = position_count_reg;
      rev_next       = revolution_count_reg;
      dir_next       = last_direction_flag;
      dir_valid_next = dir_valid_reg & (pos_mode != `QCMC_M_OFF);
      mask_cnt_next  = mask_cnt_reg;
      rev_up         = 1'b0;
      rev_dn         = 1'b0;
      do_clear       = 1'b0;
      zero_idx_set   = 1'b0;
      wrap_evt       = 1'b0;
      masked         = mask_mode & (msk_sel != `QCMC_M_OFF) & (mask_cnt_reg != 4'h0);
      if (step_up | step_dn) begin
         if (dir_valid_reg & (dir_next != step_up))
            mask_cnt_next = 4'h0;
         else if (mask_cnt_reg != 4'h0)
            mask_cnt_next = mask_cnt_reg - 4'h1;
         dir_next       = step_up;
         dir_valid_next = 1'b1;
      end
      if (step_up) begin
         if (position_count_reg == max_position_reg) begin
            wrap_evt = 1'b1;
            if (rev_mode == `QCMC_M_TWO || !masked)
               pos_next = `QCMC_CNT_RESET;
            else
               pos_next = position_count_reg + 1'b1;
            rev_up = 1'b1;
         end else
            pos_next = position_count_reg + 1'b1;
      end else if (step_dn) begin
         if (position_count_reg == `QCMC_CNT_RESET) begin
            wrap_evt = 1'b1;
            pos_next = max_position_reg;
            rev_dn   = 1'b1;
         end else
            pos_next = position_count_reg - 1'b1;
      end
      // index clear
      if (z_act && rev_mode != `QCMC_M_TWO && !(mask_mode && masked)) begin
         do_clear     = 1'b1;
         zero_idx_set = 1'b1;
         pos_next     = `QCMC_CNT_RESET;
         if (rev_mode != `QCMC_M_OFF && dir_valid_reg) begin
            rev_up = last_direction_flag;
            rev_dn = ~last_direction_flag;
         end
      end
      // wrap steps only count in modes 10 and 11
      if (!(rev_mode == `QCMC_M_TWO || rev_mode == `QCMC_M_THREE) && wrap_evt && !do_clear) begin
         rev_up = 1'b0;
         rev_dn = 1'b0;
      end
      if (rev_mode == `QCMC_M_OFF || (masked && mask_mode && rev_mode != `QCMC_M_TWO)) begin
         rev_up = 1'b0;
         rev_dn = 1'b0;
      end
      if (rev_up)
         rev_next = revolution_count_reg + 1'b1;
      else if (rev_dn)
         rev_next = revolution_count_reg - 1'b1;

      if ((wrap_evt | z_act) && mask_mode && !masked)
         mask_cnt_next = mask_len;
      if (mode_change)
         mask_cnt_next = 4'h0;

      // software writes come last so they win over a step in the same cycle
      if (pos_wr && pstop)
         pos_next = reg_wdata;
      if (rev_wr && rev_mode == `QCMC_M_OFF)
         rev_next = reg_wdata;
   end

   always @* begin
      case (reg_addr)
         `QCMC_ADR_CTRL_LOW:  rdata_next = {{(CW-8){1'b0}}, quad_control_low};
         `QCMC_ADR_CTRL_HIGH: rdata_next = {{(CW-8){1'b0}}, quad_control_high};
         `QCMC_ADR_POS:       rdata_next = position_count_reg;
         `QCMC_ADR_REV:       rdata_next = revolution_count_reg;
         `QCMC_ADR_POS_CMP:   rdata_next = position_compare_reg;
         `QCMC_ADR_SHR_CMP:   rdata_next = shared_compare_reg;
         `QCMC_ADR_MAX_POS:   rdata_next = max_position_reg;
         `QCMC_ADR_STATUS: begin
            rdata_next = {CW{1'b0}};
            rdata_next[`QCMC_ST_POS_MATCH]  = pos_match_reg;
            rdata_next[`QCMC_ST_SHR_MATCH]  = shr_match_reg;
            rdata_next[`QCMC_ST_BOTH_MATCH] = combined_match_flag;
            rdata_next[`QCMC_ST_ZERO_IDX]   = zero_index_flag;
            rdata_next[`QCMC_ST_OVF]        = ovf_reg;
            rdata_next[`QCMC_ST_UNF]        = unf_reg;
            rdata_next[`QCMC_ST_DIR]        = last_direction_flag;
            rdata_next[`QCMC_ST_DIR_VALID]  = dir_valid_reg;
         end
         default:             rdata_next = {CW{1'b0}};
      endcase
   end

   // status write: a 0 clears, a 1 keeps; hardware set wins
   wire st_wr = reg_wr & (reg_addr == `QCMC_ADR_STATUS);
   wire [CW-1:0] shr_src = quad_control_low[`QCMC_B_COMPARE_SOURCE_SELECT] ? revolution_count_reg
                                                           : position_count_reg;
   wire pos_hit  = position_count_reg == position_compare_reg;
   wire shr_hit  = shr_src == shared_compare_reg;
   wire both_hit = pos_hit & (revolution_count_reg == shared_compare_reg);

   wire wr_ctrl_high = reg_wr & (reg_addr == `QCMC_ADR_CTRL_HIGH);
   wire wr_pos_cmp   = reg_wr & (reg_addr == `QCMC_ADR_POS_CMP);
   wire wr_shr_cmp   = reg_wr & (reg_addr == `QCMC_ADR_SHR_CMP);
   wire wr_max_pos   = reg_wr & (reg_addr == `QCMC_ADR_MAX_POS);
   wire clr_pos_m    = st_wr & ~reg_wdata[`QCMC_ST_POS_MATCH];
   wire clr_shr_m    = st_wr & ~reg_wdata[`QCMC_ST_SHR_MATCH];
   wire clr_both_m   = st_wr & ~reg_wdata[`QCMC_ST_BOTH_MATCH];
   wire clr_zero     = st_wr & ~reg_wdata[`QCMC_ST_ZERO_IDX];
   wire clr_ovf      = st_wr & ~reg_wdata[`QCMC_ST_OVF];
   wire clr_unf      = st_wr & ~reg_wdata[`QCMC_ST_UNF];

   // pins are asynchronous: two stages settle them, the third keeps the old level
   always @(posedge clock) begin
      if (sys_rst) begin
         a_sync_reg <= 3'h0;
         b_sync_reg <= 3'h0;
         z_sync_reg <= 3'h0;
      end else begin
         a_sync_reg <= {a_sync_reg[1:0], phase_a_input};
         b_sync_reg <= {b_sync_reg[1:0], phase_b_input};
         z_sync_reg <= {z_sync_reg[1:0], index_input};
      end
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         quad_control_low     <= `QCMC_CTRL_RESET;
         quad_control_high    <= `QCMC_CTRL_RESET;
         position_compare_reg <= `QCMC_CNT_RESET;
         shared_compare_reg   <= `QCMC_CNT_RESET;
         max_position_reg     <= `QCMC_MAX_RESET;
      end else begin
         if (ctrl_wr_low)
            quad_control_low <= reg_wdata[7:0];
         if (wr_ctrl_high)
            quad_control_high <= reg_wdata[7:0];
         if (wr_pos_cmp)
            position_compare_reg <= reg_wdata;
         if (wr_shr_cmp)
            shared_compare_reg <= reg_wdata;
         if (wr_max_pos)
            max_position_reg <= reg_wdata;
      end
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         position_count_reg   <= `QCMC_CNT_RESET;
         revolution_count_reg <= `QCMC_CNT_RESET;
         last_direction_flag  <= 1'b0;
         dir_valid_reg        <= 1'b0;
         mask_cnt_reg         <= 4'h0;
         reg_rdata            <= {CW{1'b0}};
      end else begin
         position_count_reg   <= pos_next;
         revolution_count_reg <= rev_next;
         last_direction_flag  <= dir_next;
         dir_valid_reg        <= dir_valid_next;
         mask_cnt_reg         <= mask_cnt_next;
         reg_rdata            <= reg_rd ? rdata_next : {CW{1'b0}};
      end
   end

   // an event in the cycle of a software clear keeps its flag set
   always @(posedge clock) begin
      if (sys_rst) begin
         pos_match_reg       <= 1'b0;
         shr_match_reg       <= 1'b0;
         combined_match_flag <= 1'b0;
         zero_index_flag     <= 1'b0;
         ovf_reg             <= 1'b0;
         unf_reg             <= 1'b0;
      end else begin
         pos_match_reg       <= pos_hit | (pos_match_reg & ~clr_pos_m);
         shr_match_reg       <= shr_hit | (shr_match_reg & ~clr_shr_m);
         combined_match_flag <= both_hit | (combined_match_flag & ~clr_both_m);
         zero_index_flag     <= zero_idx_set | (zero_index_flag & ~clr_zero);
         ovf_reg             <= (wrap_evt & step_up) | (ovf_reg & ~clr_ovf);
         unf_reg             <= (wrap_evt & step_dn) | (unf_reg & ~clr_unf);
      end
   end
endmodule
`default_nettype wire

// ### bench/qcmc_counter_chk.sv
// concurrent checks on the quadrature counter ports
`timescale 1ns/1ps
`default_nettype none
`include "qcmc_regs.vh"
module qcmc_counter_chk #(
   parameter CW = 16
) (
   // clock and reset
   input wire logic                    clock,
   input wire logic                    sys_rst,
   // index pin and register port
   input wire logic                    index_input,
   input wire logic [`QCMC_ADDR_W-1:0] reg_addr,
   input wire logic [CW-1:0]           reg_wdata,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [CW-1:0]           reg_rdata,
   // status
   input wire logic                    combined_match_flag,
   input wire logic                    zero_index_flag,
   input wire logic [CW-1:0]           position_count_reg,
   input wire logic [CW-1:0]           revolution_count_reg
);
   logic [7:0]    ctl_reg;
   logic [CW-1:0] max_reg;
   logic [CW-1:0] pcmp_reg;
   logic [CW-1:0] scmp_reg;
   logic [3:0]    quiet_reg;
   logic          wr_pos;
   logic          wr_st;
   assign wr_pos = reg_wr && reg_addr == `QCMC_ADR_POS;
   assign wr_st = reg_wr && reg_addr == `QCMC_ADR_STATUS;
   // quiet time keeps a pending index clear out of the hold checks
   always @(posedge clock) begin
      if (sys_rst) begin
         ctl_reg   <= 8'h00;
         max_reg   <= {CW{1'b1}};
         pcmp_reg  <= '0;
         scmp_reg  <= '0;
         quiet_reg <= 4'h0;
      end else begin
         if (reg_wr && reg_addr == `QCMC_ADR_CTRL_LOW)
            ctl_reg <= reg_wdata[7:0];
         if (reg_wr && reg_addr == `QCMC_ADR_MAX_POS)
            max_reg <= reg_wdata;
         if (reg_wr && reg_addr == `QCMC_ADR_POS_CMP)
            pcmp_reg <= reg_wdata;
         if (reg_wr && reg_addr == `QCMC_ADR_SHR_CMP)
            scmp_reg <= reg_wdata;
         quiet_reg <= $changed(index_input) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hF};
      end
   end
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside its answer cycle");
   a_ctrl_readback: assert property (reg_rd && reg_addr == `QCMC_ADR_CTRL_LOW |=> reg_rdata[7:0] == ctl_reg)
      else $error("control low readback differs");
   a_pos_write_take: assert property (wr_pos && ctl_reg[`QCMC_B_PSTOP] && quiet_reg > 4'h5
      |=> position_count_reg == $past(reg_wdata)) else $error("position write while stopped lost");
   a_stop_holds: assert property (ctl_reg[`QCMC_B_PSTOP] && !wr_pos && quiet_reg > 4'h5
      |=> $stable(position_count_reg)) else $error("position moved while stopped");
   a_step_one: assert property ($changed(position_count_reg) && !$past(wr_pos)
      |-> position_count_reg == $past(position_count_reg) + 1'b1 || position_count_reg == '0
      || position_count_reg == $past(position_count_reg) - 1'b1 || position_count_reg == max_reg)
      else $error("position jumped");
   a_zero_sticky: assert property (zero_index_flag && !(wr_st && !reg_wdata[3]) |=> zero_index_flag)
      else $error("zero index flag dropped");
   a_match_set: assert property (position_count_reg == pcmp_reg && revolution_count_reg == scmp_reg
      |-> ##[0:2] combined_match_flag) else $error("combined match not flagged");
   a_match_sticky: assert property (combined_match_flag && !(wr_st && !reg_wdata[2]) |=> combined_match_flag)
      else $error("combined match flag dropped");
   c_zero: cover property ($rose(zero_index_flag));
   c_match: cover property ($rose(combined_match_flag));
   c_wrap: cover property ($changed(position_count_reg) && position_count_reg == max_reg);
endmodule
`default_nettype wire

// ### bench/qcmc_encoder.sv
// encoder model driving the phase and index pins
`timescale 1ns/1ps
`default_nettype none
module qcmc_encoder (
   // pacing clock
   input  wire logic clock,
   // encoder pins
   output var  logic pin_a,
   output var  logic pin_b,
   output var  logic pin_z
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
      pin_z = 1'b0;
   end
   // at least seven cycles a level so the synchroniser never merges two edges
   task automatic move(input logic a, input logic b, input logic z);
      @(posedge clock);
      pin_a <= a;
      pin_b <= b;
      pin_z <= z;
      repeat (6) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the quadrature counter mode control
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clock;
   logic        sys_rst;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   wire  [15:0] reg_rdata;
   wire         combined_match_flag;
   wire         zero_index_flag;
   wire  [15:0] position_count_reg;
   wire  [15:0] revolution_count_reg;
   wire         pin_a;
   wire         pin_b;
   wire         pin_z;
   int          num_errors;
   int          checked;
   int          cycles;
   logic [15:0] ep;
   logic        zl;
   logic [1:0]  codes [3] = '{2'h2, 2'h1, 2'h3};
   qcmc_counter #(.CW(16)) qcmc_counter_i (.clock(clock), .sys_rst(sys_rst), .phase_a_input(pin_a),
      .phase_b_input(pin_b), .index_input(pin_z), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .combined_match_flag(combined_match_flag),
      .zero_index_flag(zero_index_flag), .position_count_reg(position_count_reg),
      .revolution_count_reg(revolution_count_reg));
   qcmc_encoder qcmc_encoder_i (.clock(clock), .pin_a(pin_a), .pin_b(pin_b), .pin_z(pin_z));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      cmp(reg_rdata, e);
   endtask
   task automatic mv(input logic a, input logic b, input logic z);
      qcmc_encoder_i.move(a, b, z);
   endtask
   task automatic pa(input logic z);
      mv(1'b1, 1'b0, z);
      mv(1'b0, 1'b0, z);
   endtask
   task automatic pb(input logic z);
      mv(1'b0, 1'b1, z);
      mv(1'b0, 1'b0, z);
   endtask
   task automatic final_report;
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      sys_rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      num_errors = 0;
      checked = 0;
      cycles = 0;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      rd(4'h6, 16'hFFFF);
      rd(4'h8, 16'h0000);
      wr(4'h0, 16'h0001);
      ep = 16'h0000;
      for (int i = 1; i < 4; i++) begin
         wr(4'h1, 16'(i) << 2);
         pa(1'b0);
         ep = ep + ((i == 3) ? 16'h2 : 16'h1);
         rd(4'h2, ep);
      end
      for (int i = 1; i < 4; i++) begin
         wr(4'h1, 16'(i) << 4);
         pb(1'b0);
         ep = ep - ((i == 3) ? 16'h2 : 16'h1);
         rd(4'h2, ep);
      end
      wr(4'h0, 16'h0011);
      wr(4'h1, 16'h0008);
      pa(1'b0);
      rd(4'h2, 16'h0000);
      wr(4'h2, 16'h0005);
      rd(4'h2, 16'h0005);
      wr(4'h0, 16'h0001);
      wr(4'h2, 16'h0009);
      rd(4'h2, 16'h0005);
      wr(4'h1, 16'h0020);
      wr(4'h0, 16'h0003);
      mv(1'b1, 1'b0, 1'b0);
      mv(1'b1, 1'b1, 1'b0);
      rd(4'h2, 16'h0006);
      mv(1'b1, 1'b0, 1'b0);
      mv(1'b0, 1'b0, 1'b0);
      pb(1'b0);
      rd(4'h2, 16'h0005);
      wr(4'h1, 16'h003C);
      wr(4'h0, 16'h0002);
      mv(1'b1, 1'b0, 1'b0);
      mv(1'b1, 1'b1, 1'b0);
      mv(1'b0, 1'b1, 1'b0);
      mv(1'b0, 1'b0, 1'b0);
      @(negedge clock);
      cmp(position_count_reg, 16'h0009);
      mv(1'b0, 1'b1, 1'b0);
      mv(1'b1, 1'b1, 1'b0);
      mv(1'b1, 1'b0, 1'b0);
      mv(1'b0, 1'b0, 1'b0);
      rd(4'h2, 16'h0005);
      wr(4'h0, 16'h0011);
      wr(4'h2, 16'h0000);
      wr(4'h6, 16'h0003);
      wr(4'h1, 16'h0028);
      wr(4'h0, 16'h0009);
      pb(1'b0);
      rd(4'h2, 16'h0003);
      rd(4'h3, 16'hFFFF);
      wr(4'h3, 16'h1234);
      rd(4'h3, 16'hFFFF);
      pa(1'b0);
      rd(4'h2, 16'h0000);
      rd(4'h3, 16'h0000);
      wr(4'h0, 16'h0001);
      zl = 1'b0;
      for (int i = 0; i < 3; i++) begin
         wr(4'h1, {8'h00, codes[i], 6'h28});
         pa(zl);
         zl = ~zl;
         mv(1'b0, 1'b0, zl);
         rd(4'h2, 16'h0000);
      end
      cmp({15'h0000, zero_index_flag}, 16'h0001);
      wr(4'h7, 16'h0000);
      wr(4'h1, 16'h00A8);
      pa(zl);
      mv(1'b0, 1'b0, 1'b0);
      rd(4'h2, 16'h0001);
      cmp({15'h0000, zero_index_flag}, 16'h0000);
      wr(4'h0, 16'h0021);
      pa(1'b0);
      rd(4'h2, 16'h0001);
      mv(1'b0, 1'b0, 1'b1);
      pa(1'b1);
      rd(4'h2, 16'h0002);
      mv(1'b0, 1'b0, 1'b0);
      wr(4'h0, 16'h0000);
      wr(4'h0, 16'h0080);
      wr(4'h1, 16'h0028);
      wr(4'h0, 16'h0081);
      pa(1'b0);
      rd(4'h2, 16'h0001);
      wr(4'h4, 16'h0007);
      wr(4'h7, 16'h0000);
      repeat (2) @(negedge clock);
      cmp({15'h0000, combined_match_flag}, 16'h0000);
      wr(4'h4, 16'h0001);
      repeat (2) @(negedge clock);
      cmp({15'h0000, combined_match_flag}, 16'h0001);
      wr(4'h5, 16'h0001);
      wr(4'h7, 16'h0000);
      rd(4'h7, 16'h0083);
      wr(4'h0, 16'h00C1);
      wr(4'h7, 16'h0000);
      rd(4'h7, 16'h0081);
      wr(4'h0, 16'h00C0);
      wr(4'h0, 16'h0040);
      wr(4'h1, 16'h00A9);
      wr(4'h0, 16'h0041);
      pa(1'b0);
      mv(1'b0, 1'b0, 1'b1);
      pa(1'b1);
      mv(1'b0, 1'b0, 1'b0);
      mv(1'b0, 1'b0, 1'b1);
      rd(4'h2, 16'h0001);
      pa(1'b1);
      mv(1'b0, 1'b0, 1'b0);
      mv(1'b0, 1'b0, 1'b1);
      rd(4'h2, 16'h0000);
      pa(1'b1);
      wr(4'h0, 16'h0042);
      mv(1'b0, 1'b0, 1'b0);
      mv(1'b0, 1'b0, 1'b1);
      rd(4'h2, 16'h0000);
      final_report();
   end
endmodule
bind qcmc_counter qcmc_counter_chk #(.CW(CW)) qcmc_counter_chk_i (.clock(clock), .sys_rst(sys_rst),
   .index_input(index_input), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .combined_match_flag(combined_match_flag), .zero_index_flag(zero_index_flag),
   .position_count_reg(position_count_reg), .revolution_count_reg(revolution_count_reg));
`default_nettype wire
